/* src/wit_edge_sync.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-stage synchroniser with rising edge detect
// ------------------------------------------------------------
module wit_edge_sync
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic din,
   output logic rise
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } wit_sync_st_t;

   wit_sync_st_t st_r;
   wit_sync_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (ce)
      begin
         st_nxt.s1 = din;
         st_nxt.s2 = st_r.s1;
         st_nxt.s3 = st_r.s2;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // Only the second and third stages feed the edge detector
   assign rise = ce & st_r.s2 & ~st_r.s3;

endmodule : wit_edge_sync

/* src/wit_pkg.sv */
// ------------------------------------------------------------
// Watch and interval timer shared definitions
// ------------------------------------------------------------
package wit_pkg;

   // ---------------------------------------------------------
   // Widths
   // ---------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int CTRL_W = 8;
   localparam int PRE_W = 11;
   localparam int CNT_W = 5;
   localparam int DIV_W = 7;

   // ---------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------
   localparam logic [ADDR_W-1:0] WATCH_MODE_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
   localparam logic [CTRL_W-1:0] WATCH_MODE_RST = 8'h00;

   // ---------------------------------------------------------
   // Field positions of watch_mode_reg
   // ---------------------------------------------------------
   localparam int TIMER_RUN_EN_BIT = 0;
   localparam int COUNTER5_START_BIT = 1;
   localparam int WATCH_SEL_LSB = 2;
   localparam int WATCH_SEL_W = 2;
   localparam int INTERVAL_SEL_LSB = 4;
   localparam int INTERVAL_SEL_W = 3;
   localparam int COUNT_CLK_SEL_BIT = 7;

   // ---------------------------------------------------------
   // Field positions of the status word
   // ---------------------------------------------------------
   localparam int STATUS_PRE_LSB = 0;
   localparam int STATUS_CNT_LSB = 16;

   // ---------------------------------------------------------
   // Period codes and counts
   // ---------------------------------------------------------
   localparam logic [WATCH_SEL_W-1:0] WSEL_P14 = 2'h0;
   localparam logic [WATCH_SEL_W-1:0] WSEL_P13 = 2'h1;
   localparam logic [WATCH_SEL_W-1:0] WSEL_P5 = 2'h2;
   localparam logic [WATCH_SEL_W-1:0] WSEL_P4 = 2'h3;
   localparam logic [3:0] INTERVAL_BASE_EXP = 4'h4;
   localparam logic [PRE_W-1:0] PRE_ONES = 11'h7ff;
   localparam logic [PRE_W-1:0] PRE_TAP4 = 11'h00f;
   localparam logic [PRE_W-1:0] PRE_TAP5 = 11'h01f;
   localparam logic [PRE_W-1:0] PRE_TAP9 = 11'h1ff;
   localparam logic [CNT_W-1:0] CNT_FULL = 5'h1f;
   localparam logic [CNT_W-2:0] CNT_HALF = 4'hf;
   localparam logic [DIV_W-1:0] DIV_ONES = 7'h7f;

   // ---------------------------------------------------------
   // Bus carriers
   // ---------------------------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0] byteenable;
   } wit_avs_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic waitrequest;
   } wit_avs_rsp_t;

endpackage : wit_pkg

/* src/wit_timer.sv */
`timescale 1ns/1ps
// How it works
// RULE1: count clock is sys/128 or subsystem clock
// RULE2: watch counts only when enable and start
// RULE3: both bits clear: counter cleared, watch stops
// RULE4: start bit clear alone restarts counter, prescaler runs
// RULE5: restart first watch pulse off by 512 max
// RULE6: watch period codes 2^14, 2^13, 2^5, 2^4
// RULE7: interval pulse repeats every interval while enabled
// RULE8: interval is 2^(4+code) count clocks
// RULE9: interval runs on enable bit alone
// RULE10: first watch pulse late up to 512; code makes it up to 512 early instead
// RULE11: watch and interval run together, shared prescaler
// RULE12: enable clear stops, clears prescaler and counter
// RULE13: software keeps bits 7..4 fixed while running
// RULE14: reset clears whole control register
// RULE15: short watch from taps, long from counter
// RULE16: each interrupt is a one-cycle pulse
module wit_timer
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic SUB_CLK,
   input wire wit_pkg::wit_avs_req_t AVS_REQ,
   output wit_pkg::wit_avs_rsp_t AVS_RSP,
   output logic WATCH_IRQ,
   output logic INTERVAL_IRQ
);

   // ---------------------------------------------------------
   // State
   // ---------------------------------------------------------
   typedef struct packed {
      logic [wit_pkg::CTRL_W-1:0] watch_mode_reg;
      logic [wit_pkg::DIV_W-1:0] div;
      logic [wit_pkg::PRE_W-1:0] pre;
      logic [wit_pkg::CNT_W-1:0] cnt;
      logic watch_irq;
      logic interval_irq;
      logic ack;
      logic [wit_pkg::DATA_W-1:0] rdata;
   } wit_state_t;

   wit_state_t st_r;
   wit_state_t st_nxt;

   logic sub_rise;
   logic timer_run_en;
   logic counter5_start;
   logic count_clk_sel;
   logic [wit_pkg::WATCH_SEL_W-1:0] watch_sel;
   logic [wit_pkg::INTERVAL_SEL_W-1:0] interval_sel;
   logic [3:0] interval_exp;
   logic [wit_pkg::PRE_W-1:0] interval_mask;
   logic timer_count_clk;
   logic cnt_tick;
   logic watch_hit;
   logic interval_hit;
   logic bus_req;
   logic [wit_pkg::DATA_W-1:0] status_word;

   // ---------------------------------------------------------
   // Subsystem clock arrives from a pin: synchronise first
   // ---------------------------------------------------------
   wit_edge_sync u_sub_sync
   (
      .clk(SYS_CLK),
      .nrst(NRST),
      .ce(CE),
      .din(SUB_CLK),
      .rise(sub_rise)
   );

   // ---------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------
   assign timer_run_en = st_r.watch_mode_reg[wit_pkg::TIMER_RUN_EN_BIT];
   assign counter5_start =
      st_r.watch_mode_reg[wit_pkg::COUNTER5_START_BIT];
   assign count_clk_sel = st_r.watch_mode_reg[wit_pkg::COUNT_CLK_SEL_BIT];
   assign watch_sel = st_r.watch_mode_reg[wit_pkg::WATCH_SEL_LSB +:
      wit_pkg::WATCH_SEL_W];
   assign interval_sel = st_r.watch_mode_reg[wit_pkg::INTERVAL_SEL_LSB +:
      wit_pkg::INTERVAL_SEL_W];
   // Bits 7..4 are not guarded: changing them mid-run gives one
   // irregular period, which software is expected to avoid (see RULE13)

   // ---------------------------------------------------------
   // Count clock enable, one system cycle wide
   // ---------------------------------------------------------
   always_comb
   begin
      // see RULE1
      if (count_clk_sel)
         timer_count_clk = sub_rise;
      else
         timer_count_clk = CE & (st_r.div == wit_pkg::DIV_ONES);
      timer_count_clk = timer_count_clk & timer_run_en;
   end

   // ---------------------------------------------------------
   // Period decode
   // ---------------------------------------------------------
   always_comb
   begin
      interval_exp = {1'b0, interval_sel} + wit_pkg::INTERVAL_BASE_EXP;
      // Low 4+code prescaler bits all ones marks the boundary (see RULE8)
      interval_mask = ~(wit_pkg::PRE_ONES << interval_exp);
      interval_hit = timer_count_clk &
         ((st_r.pre & interval_mask) == interval_mask); // see RULE7
      // Counter advances once per 2^9 prescaler stage (see RULE15)
      cnt_tick = timer_count_clk &
         ((st_r.pre & wit_pkg::PRE_TAP9) == wit_pkg::PRE_TAP9);
      unique case (watch_sel) // see RULE6
         wit_pkg::WSEL_P14:
            watch_hit = cnt_tick & (st_r.cnt == wit_pkg::CNT_FULL);
         wit_pkg::WSEL_P13:
            watch_hit = cnt_tick &
               (st_r.cnt[wit_pkg::CNT_W-2:0] == wit_pkg::CNT_HALF);
         wit_pkg::WSEL_P5:
            watch_hit = timer_count_clk &
               ((st_r.pre & wit_pkg::PRE_TAP5) == wit_pkg::PRE_TAP5);
         wit_pkg::WSEL_P4:
            watch_hit = timer_count_clk &
               ((st_r.pre & wit_pkg::PRE_TAP4) == wit_pkg::PRE_TAP4);
      endcase
      // Watch needs both enable and start (see RULE2)
      watch_hit = watch_hit & counter5_start;
   end

   // ---------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------
   assign bus_req = AVS_REQ.read | AVS_REQ.write;

   always_comb
   begin
      status_word = '0;
      status_word[wit_pkg::STATUS_PRE_LSB +: wit_pkg::PRE_W] = st_r.pre;
      status_word[wit_pkg::STATUS_CNT_LSB +: wit_pkg::CNT_W] = st_r.cnt;
   end

   // ---------------------------------------------------------
   // Next state
   // ---------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      if (CE)
      begin
         st_nxt.watch_irq = watch_hit; // see RULE16
         st_nxt.interval_irq = interval_hit; // see RULE16

         // Divider and prescaler run on the enable bit alone, so the
         // interval side ignores the start bit (see RULE9, RULE11)
         if (!timer_run_en)
         begin
            st_nxt.div = '0; // see RULE12
            st_nxt.pre = '0; // see RULE12
         end
         else
         begin
            st_nxt.div = st_r.div + 7'h01;
            if (timer_count_clk)
               st_nxt.pre = st_r.pre + 11'h001;
         end

         // Prescaler keeps its phase across a restart, so the first
         // long watch pulse may land up to 512 counts off (see RULE5)
         if (!timer_run_en || !counter5_start)
            st_nxt.cnt = '0; // see RULE3
         else if (cnt_tick)
            st_nxt.cnt = st_r.cnt + 5'h01; // see RULE4
         // No phase alignment on start: first pulse early (see RULE10)

         // One wait state, then the answer
         if (st_r.ack)
            st_nxt.ack = 1'b0;
         else if (bus_req)
         begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = '0;
            if (AVS_REQ.read)
            begin
               if (AVS_REQ.address == wit_pkg::WATCH_MODE_OFS)
                  st_nxt.rdata[wit_pkg::CTRL_W-1:0] = st_r.watch_mode_reg;
               else if (AVS_REQ.address == wit_pkg::STATUS_OFS)
                  st_nxt.rdata = status_word;
            end
         end

         // Write lands at the edge that sees waitrequest low
         if (st_r.ack && AVS_REQ.write && AVS_REQ.byteenable[0] &&
             AVS_REQ.address == wit_pkg::WATCH_MODE_OFS)
            st_nxt.watch_mode_reg =
               AVS_REQ.writedata[wit_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         st_r <= '0;
         st_r.watch_mode_reg <= wit_pkg::WATCH_MODE_RST; // see RULE14
      end
      else
         st_r <= st_nxt;
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   // One driver for the whole response word
   assign AVS_RSP = '{readdata: st_r.rdata,
      waitrequest: bus_req & ~st_r.ack};
   assign WATCH_IRQ = st_r.watch_irq;
   assign INTERVAL_IRQ = st_r.interval_irq;

endmodule : wit_timer

/* verif/testbench.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------
// Self-checking bench for the watch and interval timer
// ----------------------------------------------------------
module testbench;
   localparam logic [3:0] MO = wit_pkg::WATCH_MODE_OFS;
   localparam logic [3:0] ST = wit_pkg::STATUS_OFS;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [1:0] sub_cnt = 2'h0;
   wit_pkg::wit_avs_req_t req = '0;
   wit_pkg::wit_avs_rsp_t rsp;
   logic watch_irq;
   logic int_irq;
   logic [31:0] q;
   int n_errors = 0;
   int check_count = 0;
   int n_watch = 0;
   always #25 sys_clk = ~sys_clk;
   // Subsystem clock at a quarter of the system rate keeps runs short
   always @(posedge sys_clk) sub_cnt <= sub_cnt + 2'h1;
   always @(posedge sys_clk) if (watch_irq === 1'b1) n_watch++;
   wit_timer u_dut
   (
      .SYS_CLK(sys_clk),
      .NRST(nrst),
      .CE(ce),
      .SUB_CLK(sub_cnt[1]),
      .AVS_REQ(req),
      .AVS_RSP(rsp),
      .WATCH_IRQ(watch_irq),
      .INTERVAL_IRQ(int_irq)
   );
   task automatic check(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] rd);
      int n;
      n = 0;
      req.read <= ~wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= d;
      req.byteenable <= 4'hf;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      // One wait state: answer sampled at the second edge
      check("bus wait states", n, 32'h0000_0002);
      req.read <= 1'b0;
      req.write <= 1'b0;
      // Idle edge so the next request never lands in the same time step
      @(posedge sys_clk);
   endtask : bus
   task automatic gap(input logic w, input int exp, input string nm);
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while ((w ? watch_irq : int_irq) !== 1'b1 && n < 20000);
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while ((w ? watch_irq : int_irq) !== 1'b1 && n < 20000);
      check(nm, n, exp);
   endtask : gap
   task automatic t_reset();
      bus(1'b0, MO, 32'h0, q);
      check("mode after reset", q, 32'h0);
      bus(1'b1, 4'h8, 32'h0000_00ff, q);
      bus(1'b0, 4'h8, 32'h0, q);
      check("unmapped read", q, 32'h0);
      bus(1'b0, ST, 32'h0, q);
      check("idle status", q, 32'h0);
   endtask : t_reset
   task automatic t_sys();
      int w;
      bus(1'b1, MO, 32'h0d, q);
      w = n_watch;
      gap(1'b0, 16 * 128, "interval on sys clock");
      check("watch idle without start", n_watch, w);
      bus(1'b1, MO, 32'h0, q);
   endtask : t_sys
   task automatic t_codes();
      for (int c = 0; c < 8; c++)
      begin
         bus(1'b1, MO, 32'h81 | (c << 4), q);
         gap(1'b0, (16 << c) * 4, "interval code");
         bus(1'b1, MO, 32'h0, q);
      end
   endtask : t_codes
   task automatic t_watch();
      bus(1'b1, MO, 32'h8f, q);
      bus(1'b0, MO, 32'h0, q);
      check("mode readback", q, 32'h8f);
      gap(1'b1, 16 * 4, "watch short period");
      gap(1'b0, 16 * 4, "interval beside watch");
      bus(1'b1, MO, 32'h8b, q);
      gap(1'b1, 32 * 4, "watch second period");
   endtask : t_watch
   task automatic t_restart();
      bus(1'b1, MO, 32'h87, q);
      repeat (4200) @(posedge sys_clk);
      bus(1'b0, ST, 32'h0, q);
      check("counter advancing", q[20:16] != 5'h0, 1'b1);
      bus(1'b1, MO, 32'h85, q);
      bus(1'b0, ST, 32'h0, q);
      check("counter cleared", q[20:16], 5'h0);
      check("prescaler kept", q[10:0] != 11'h0, 1'b1);
      gap(1'b0, 64, "interval without start");
      bus(1'b1, MO, 32'h0, q);
      bus(1'b0, ST, 32'h0, q);
      check("stopped status", q, 32'h0);
      check("counter stopped", q[20:16], 5'h0);
   endtask : t_restart
   task automatic t_freeze();
      int n;
      bus(1'b1, MO, 32'h01, q);
      gap(1'b0, 16 * 128, "interval before freeze");
      repeat (100) @(posedge sys_clk);
      ce <= 1'b0;
      repeat (500) @(posedge sys_clk);
      ce <= 1'b1;
      // Frozen edges push the next pulse out by exactly their count
      n = 600;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while (int_irq !== 1'b1 && n < 20000);
      check("interval across freeze", n, 16 * 128 + 500);
      bus(1'b1, MO, 32'h0, q);
   endtask : t_freeze
   task automatic t_mid_reset();
      bus(1'b1, MO, 32'h8f, q);
      repeat (200) @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      bus(1'b0, MO, 32'h0, q);
      check("mode after mid reset", q, 32'h0);
      bus(1'b0, ST, 32'h0, q);
      check("status after mid reset", q, 32'h0);
   endtask : t_mid_reset
   task automatic conclude();
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   initial
   begin
      #4_000_000;
      n_errors++;
      conclude();
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_sys();
      t_codes();
      t_watch();
      t_restart();
      t_freeze();
      t_mid_reset();
      conclude();
   end
endmodule : testbench

/* verif/wit_timer_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------
// Port checker for the watch and interval timer
// ----------------------------------------------------------
module wit_chk
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic SUB_CLK,
   input wire wit_pkg::wit_avs_req_t AVS_REQ,
   input wire wit_pkg::wit_avs_rsp_t AVS_RSP,
   input wire logic WATCH_IRQ,
   input wire logic INTERVAL_IRQ
);
   logic [7:0] ctrl_r;
   logic req;
   logic done;
   logic at_mode;
   assign req = AVS_REQ.read | AVS_REQ.write;
   assign done = req & ~AVS_RSP.waitrequest;
   assign at_mode = AVS_REQ.address == wit_pkg::WATCH_MODE_OFS;
   // Shadow of the control byte, so pulses can be tied to their enables
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
         ctrl_r <= 8'h00;
      else if (done & CE & AVS_REQ.write & at_mode & AVS_REQ.byteenable[0])
         ctrl_r <= AVS_REQ.writedata[7:0];
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   a_watch_pulse_gap: assert property (
      WATCH_IRQ |=> (!WATCH_IRQ)[*8])
      else $error("watch pulse not single");
   a_int_pulse_gap: assert property (
      INTERVAL_IRQ |=> (!INTERVAL_IRQ)[*8])
      else $error("interval pulse not single");
   a_watch_needs_start: assert property (
      WATCH_IRQ |-> $past(ctrl_r[0] & ctrl_r[1]))
      else $error("watch pulse while stopped");
   a_int_needs_run: assert property (
      INTERVAL_IRQ |-> $past(ctrl_r[0]))
      else $error("interval pulse while stopped");
   a_one_wait_state: assert property (req && AVS_RSP.waitrequest && CE
      |=> !AVS_RSP.waitrequest || !req)
      else $error("more than one wait state");
   a_wait_rearmed: assert property (done |=> AVS_RSP.waitrequest || !req)
      else $error("no wait state after grant");
   a_mode_readback: assert property (
      AVS_REQ.read && done && at_mode
      |-> AVS_RSP.readdata == {24'h00_0000, ctrl_r})
      else $error("mode read differs from last write");
   // Status is mapped too, so only the two known offsets are exempt
   a_unmapped_zero: assert property (AVS_REQ.read && done
      && AVS_REQ.address != wit_pkg::WATCH_MODE_OFS
      && AVS_REQ.address != wit_pkg::STATUS_OFS
      |-> AVS_RSP.readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule : wit_chk
bind wit_timer wit_chk u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE),
   .SUB_CLK(SUB_CLK), .AVS_REQ(AVS_REQ), .AVS_RSP(AVS_RSP),
   .WATCH_IRQ(WATCH_IRQ), .INTERVAL_IRQ(INTERVAL_IRQ));
